// ===== hw/dip_slave.sv
// dip_slave: write-only two-wire slave of a single voltage dac
// assumes: bus lines and select pins arrive unsynchronised; clk far above scl
//
// Contract
// - sample data on serial clock rising edges
// - data released except low during acknowledge
// - master idles both lines high
// - data falling with clock high is start
// - data rising with clock high is stop
// - hold data low through accepted ack pulse
// - refuse reads: no ack, no data
// - three-state select pins give 27 addresses
// - address from pin index formula
// - also accept fixed broadcast address
// - drive select pins to detect floating
// - update falling edge after full word copies
// - update held low before full word applies it on completion
// - update pin low blocks power-down command
// - power-up loads zero or mid-scale code
// - ack three data bytes then execute
// - extra data bytes not acknowledged
// - command nibble then 16-bit data word
// - decode write, update, both, power-down, nop
`timescale 1ns/1ps
`default_nettype none
module dip_slave #(
   parameter int RES_BITS  = 16,
   parameter bit MID_SCALE = 1'b0
) (
   input  wire logic                clk,
   input  wire logic                reset_n,
   dip_if.slave                     bus,
   input  wire logic [2:0]          selIn,
   output logic      [2:0]          selOut,
   output logic      [2:0]          selOe_n,
   input  wire logic                asyncUpdate_n,
   output logic      [RES_BITS-1:0] dacCode,
   output logic      [RES_BITS-1:0] inputCode,
   output logic                     poweredDown,
   output logic                     addrReady
);
   initial begin
      if (RES_BITS != 12 && RES_BITS != 14 && RES_BITS != 16)
         $error("dip_slave: RES_BITS must be 12, 14 or 16");
   end

   localparam logic [15:0] RESET_CODE = MID_SCALE ? 16'h8000 : 16'h0000;

   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_ADDR   = 3'b001,
      S_DATA   = 3'b010,
      S_ACK    = 3'b011,
      S_IGNORE = 3'b100
   } dip_link_t;

   typedef enum logic [1:0] {
      P_HIGH = 2'b00,
      P_LOW  = 2'b01,
      P_DONE = 2'b10
   } dip_sense_t;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [5:0] syncA;
   logic [5:0] syncB;
   logic       sclPrev;
   logic       sdaPrev;
   logic       updPrev;

   // two flops before any logic sees a pin
   always_ff @(posedge clk) begin
      syncA <= {selIn, asyncUpdate_n, bus.sda, bus.scl};
      syncB <= syncA;
   end

   wire logic       scl   = syncB[0];
   wire logic       sda   = syncB[1];
   wire logic       upd_n = syncB[2];
   wire logic [2:0] sel   = syncB[5:3];

   // previous samples for edge detection
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
         updPrev <= 1'b1;
      end else begin
         sclPrev <= scl;
         sdaPrev <= sda;
         updPrev <= upd_n;
      end
   end

   wire logic sclRise  = scl & ~sclPrev;
   wire logic sclFall  = ~scl & sclPrev;
   wire logic startCnd = scl & sclPrev & sdaPrev & ~sda;
   wire logic stopCnd  = scl & sclPrev & ~sdaPrev & sda;
   wire logic updFall  = updPrev & ~upd_n;

   // ----------------------------------------------------------------
   // select pin sensing
   // ----------------------------------------------------------------
   dip_sense_t sense;
   logic [3:0] senseCnt;
   logic [2:0] readHigh;
   logic [2:0] readLow;
   logic [1:0] pinState [3];
   logic [4:0] pinIndex;
   logic [6:0] pinAddr;

   // drive each pin high then low; a pin that follows both is floating
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sense    <= P_HIGH;
         senseCnt <= 4'h0;
         readHigh <= 3'h0;
         readLow  <= 3'h0;
      end else if (sense != P_DONE) begin
         senseCnt <= senseCnt + 4'h1;
         if (senseCnt == 4'(dip_pkg::SENSE_CYC - 1)) begin
            senseCnt <= 4'h0;
            if (sense == P_HIGH) begin
               readHigh <= sel;
               sense    <= P_LOW;
            end else begin
               readLow <= sel;
               sense   <= P_DONE;
            end
         end
      end
   end

   assign selOe_n   = (sense == P_DONE) ? 3'h7 : 3'h0;
   assign selOut    = (sense == P_HIGH) ? 3'h7 : 3'h0;
   assign addrReady = (sense == P_DONE);

   // per pin three-state decode
   for (genvar k = 0; k < 3; k++) begin : g_pin
      always_comb begin
         if (readHigh[k] && !readLow[k])
            pinState[k] = dip_pkg::PIN_FLOAT;
         else if (readHigh[k])
            pinState[k] = dip_pkg::PIN_HIGH;
         else
            pinState[k] = dip_pkg::PIN_LOW;
      end
   end

   // index = 9*p2 + 3*p1 + p0, then split into address fields
   always_comb begin
      pinIndex = 5'(pinState[2] * 4'd9) + 5'(pinState[1] * 2'd3) + 5'(pinState[0]);
      pinAddr  = {pinIndex[4:2] + dip_pkg::ADDR_BASE, 2'b00, pinIndex[1:0]};
   end

   // ----------------------------------------------------------------
   // link receiver
   // ----------------------------------------------------------------
   dip_link_t   link;
   logic [3:0]  bitCnt;
   logic [2:0]  byteCnt;     // data bytes accepted in this transfer
   logic [23:0] shift;
   logic        ackDrive;
   logic        isAddr;
   logic        execNow;

   wire logic addrMatch = (shift[7:1] == pinAddr) | (shift[7:1] == dip_pkg::GLOBAL_ADDR);

   // byte framing, acknowledge and transfer state
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         link     <= S_IDLE;
         bitCnt   <= 4'h0;
         byteCnt  <= 3'h0;
         shift    <= 24'h0;
         ackDrive <= 1'b0;
         isAddr   <= 1'b0;
         execNow  <= 1'b0;
      end else begin
         execNow <= 1'b0;
         if (startCnd) begin
            link     <= addrReady ? S_ADDR : S_IGNORE;
            bitCnt   <= 4'h0;
            byteCnt  <= 3'h0;
            ackDrive <= 1'b0;
         end else if (stopCnd) begin
            link     <= S_IDLE;
            ackDrive <= 1'b0;
         end else begin
            case (link)
               S_ADDR, S_DATA: begin
                  if (sclRise && bitCnt != dip_pkg::ACK_BIT) begin
                     shift  <= {shift[22:0], sda};
                     bitCnt <= bitCnt + 4'h1;
                  end else if (sclFall && bitCnt == dip_pkg::ACK_BIT) begin
                     isAddr <= (link == S_ADDR);
                     link   <= S_ACK;
                     if (link == S_ADDR)
                        ackDrive <= addrMatch & ~shift[0];
                     else
                        ackDrive <= (byteCnt < dip_pkg::DATA_BYTES);
                  end
               end
               S_ACK: begin
                  if (sclFall) begin               // release after 9th pulse
                     ackDrive <= 1'b0;
                     bitCnt   <= 4'h0;
                     if (!ackDrive && isAddr) begin
                        link <= S_IGNORE;
                     end else begin
                        link <= S_DATA;
                        if (!isAddr && ackDrive) begin
                           byteCnt <= byteCnt + 3'h1;
                           execNow <= (byteCnt == dip_pkg::DATA_BYTES - 3'h1);
                        end
                     end
                  end
               end
               S_IGNORE, S_IDLE: ackDrive <= 1'b0;
               default: link <= S_IDLE;
            endcase
         end
      end
   end

   assign bus.sdaSlaveOut  = 1'b0;
   assign bus.sdaSlaveOe_n = ~ackDrive;

   // ----------------------------------------------------------------
   // command execution and dac registers
   // ----------------------------------------------------------------
   logic [15:0] inputReg;
   logic [15:0] dacReg;
   logic        wordReady;
   logic [3:0]  cmd;
   logic [15:0] word;
   logic [15:0] next_input;
   logic        doUpdate;

   // decode the finished 24-bit word
   always_comb begin
      cmd        = shift[dip_pkg::CMD_MSB:dip_pkg::CMD_LSB];
      word       = shift[15:0];
      next_input = inputReg;
      doUpdate   = 1'b0;
      case (cmd)
         dip_pkg::CMD_WRITE:        next_input = word;
         dip_pkg::CMD_UPDATE:       doUpdate   = 1'b1;
         dip_pkg::CMD_WRITE_UPDATE: begin
            next_input = word;
            doUpdate   = 1'b1;
         end
         default:                   doUpdate   = 1'b0;
      endcase
   end

   // input and dac registers move only on a whole word or an armed update edge
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         inputReg    <= RESET_CODE;
         dacReg      <= RESET_CODE;
         poweredDown <= 1'b0;
         wordReady   <= 1'b0;
      end else begin
         if (execNow) begin
            inputReg  <= next_input;
            wordReady <= 1'b1;
            if (doUpdate || !upd_n) begin          // held-low update also applies
               dacReg      <= next_input;
               poweredDown <= 1'b0;
            end else if (cmd == dip_pkg::CMD_POWER_DOWN) begin
               poweredDown <= 1'b1;                // only while update high
            end
         end else begin
            if (startCnd)
               wordReady <= 1'b0;                  // new word in flight
            if (updFall) begin
               poweredDown <= 1'b0;
               if (wordReady)                      // start clears it
                  dacReg <= inputReg;
            end
         end
      end
   end

   assign dacCode   = dacReg[15 -: RES_BITS];
   assign inputCode = inputReg[15 -: RES_BITS];
endmodule // dip_slave
`default_nettype wire

// ===== hw/dip_pkg.sv
// dip_pkg: shared constants of the dac two-wire write port
// assumes: both ends run on a 100 MHz clk
package dip_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;
   localparam int LINK_PERIOD_NS = 2500;               // 400 kHz serial clock
   localparam int QUARTER_NS     = LINK_PERIOD_NS / 4;
   localparam int QUARTER_CYC    = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SENSE_CYC      = 8;                  // settle time per select probe
   // ----------------------------------------------------------------
   // addressing
   // ----------------------------------------------------------------
   localparam logic [6:0] GLOBAL_ADDR = 7'h73;         // broadcast address
   localparam logic [1:0] PIN_LOW     = 2'h0;
   localparam logic [1:0] PIN_FLOAT   = 2'h1;
   localparam logic [1:0] PIN_HIGH    = 2'h2;
   localparam logic [2:0] ADDR_BASE   = 3'h1;          // added to index / 4
   // ----------------------------------------------------------------
   // framing and command word
   // ----------------------------------------------------------------
   localparam logic [3:0] ACK_BIT    = 4'h8;           // bit index of ack slot
   localparam logic [2:0] DATA_BYTES = 3'h3;
   localparam int         CMD_MSB    = 23;
   localparam int         CMD_LSB    = 20;
   localparam logic [3:0] CMD_WRITE        = 4'h0;
   localparam logic [3:0] CMD_UPDATE       = 4'h1;
   localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
   localparam logic [3:0] CMD_POWER_DOWN   = 4'h4;
   localparam logic [3:0] CMD_NOP          = 4'hf;
endpackage

// ===== hw/dip_if.sv
// dip_if: the two open-drain bus lines between master and dac port
// assumes: pull-ups on both lines; a driver only ever pulls low
`timescale 1ns/1ps
`default_nettype none
interface dip_if;
   logic sclMasterOut;
   logic sclMasterOe_n;
   logic sdaMasterOut;
   logic sdaMasterOe_n;
   logic sdaSlaveOut;
   logic sdaSlaveOe_n;
   logic scl;
   logic sda;
   // wired-and with pull-up: a line is low while any end enables its driver
   assign scl = sclMasterOe_n | sclMasterOut;
   assign sda = (sdaMasterOe_n | sdaMasterOut) & (sdaSlaveOe_n | sdaSlaveOut);
   modport master (input scl, input sda, output sclMasterOut, output sclMasterOe_n,
                   output sdaMasterOut, output sdaMasterOe_n);
   modport slave  (input scl, input sda, output sdaSlaveOut, output sdaSlaveOe_n);
endinterface
`default_nettype wire

// ===== hw/dip_master.sv
// dip_master: two-wire bus master that writes a burst of bytes
// assumes: open-drain lines with pull-ups; one user request at a time
`timescale 1ns/1ps
`default_nettype none
module dip_master #(
   parameter int MAX_BYTES = 5
) (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   dip_if.master                       bus,
   input  wire logic                   startReq,
   input  wire logic [8*MAX_BYTES-1:0] txData,
   input  wire logic [2:0]             byteCount,
   output logic                        busy,
   output logic                        done,
   output logic      [MAX_BYTES-1:0]   ackSeen
);
   initial begin
      if (MAX_BYTES < 1 || MAX_BYTES > 7)
         $error("dip_master: MAX_BYTES must be 1 to 7");
   end

   typedef enum logic [1:0] {
      M_IDLE  = 2'b00,
      M_START = 2'b01,
      M_BIT   = 2'b10,
      M_STOP  = 2'b11
   } dip_mst_t;

   // ----------------------------------------------------------------
   // data line synchroniser
   // ----------------------------------------------------------------
   logic sdaA;
   logic sdaB;

   always_ff @(posedge clk) begin
      sdaA <= bus.sda;
      sdaB <= sdaA;
   end

   // ----------------------------------------------------------------
   // quarter-period sequencer
   // ----------------------------------------------------------------
   dip_mst_t               state;
   logic [7:0]             qCnt;
   logic [1:0]             phase;
   logic [3:0]             bitIdx;
   logic [2:0]             byteIdx;
   logic [2:0]             byteLast;
   logic [8*MAX_BYTES-1:0] txShift;
   logic                   sclLow;
   logic                   sdaLow;

   wire logic tick = (qCnt == 8'(dip_pkg::QUARTER_CYC - 1));

   // quarter counter runs only during a transfer
   always_ff @(posedge clk) begin
      if (!reset_n || state == M_IDLE || tick)
         qCnt <= 8'h0;
      else
         qCnt <= qCnt + 8'h1;
   end

   // start, bits with ack slot, stop; lines idle released high
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state    <= M_IDLE;
         phase    <= 2'h0;
         bitIdx   <= 4'h0;
         byteIdx  <= 3'h0;
         byteLast <= 3'h0;
         txShift  <= '0;
         sclLow   <= 1'b0;
         sdaLow   <= 1'b0;
         done     <= 1'b0;
         ackSeen  <= '0;
      end else begin
         done <= 1'b0;
         case (state)
            M_IDLE: begin
               if (startReq && byteCount != 3'h0) begin
                  state    <= M_START;
                  phase    <= 2'h0;
                  txShift  <= txData;
                  byteLast <= byteCount - 3'h1;
                  byteIdx  <= 3'h0;
                  bitIdx   <= 4'h0;
                  ackSeen  <= '0;
               end
            end
            M_START: begin
               if (tick) begin
                  phase <= phase + 2'h1;
                  if (phase == 2'h0)
                     sdaLow <= 1'b1;               // data falls, clock high
                  else begin
                     sclLow <= 1'b1;
                     phase  <= 2'h0;
                     state  <= M_BIT;
                  end
               end
            end
            M_BIT: begin
               if (tick) begin
                  phase <= phase + 2'h1;
                  case (phase)
                     2'h0: sdaLow <= (bitIdx == dip_pkg::ACK_BIT) ? 1'b0
                                     : ~txShift[8*MAX_BYTES-1];
                     2'h1: sclLow <= 1'b0;
                     2'h2: if (bitIdx == dip_pkg::ACK_BIT)
                              ackSeen[byteIdx] <= ~sdaB;
                     default: begin
                        sclLow <= 1'b1;
                        if (bitIdx == dip_pkg::ACK_BIT) begin
                           bitIdx  <= 4'h0;
                           byteIdx <= byteIdx + 3'h1;
                           if (byteIdx == byteLast)
                              state <= M_STOP;
                        end else begin
                           bitIdx  <= bitIdx + 4'h1;
                           txShift <= {txShift[8*MAX_BYTES-2:0], 1'b0};
                        end
                     end
                  endcase
               end
            end
            M_STOP: begin
               if (tick) begin
                  phase <= phase + 2'h1;
                  case (phase)
                     2'h0:    sdaLow <= 1'b1;
                     2'h1:    sclLow <= 1'b0;
                     2'h2:    sdaLow <= 1'b0;        // data rises, clock high
                     default: begin
                        state <= M_IDLE;
                        done  <= 1'b1;
                     end
                  endcase
               end
            end
            default: state <= M_IDLE;
         endcase
      end
   end

   assign busy              = (state != M_IDLE);
   assign bus.sclMasterOut  = 1'b0;
   assign bus.sclMasterOe_n = ~sclLow;
   assign bus.sdaMasterOut  = 1'b0;
   assign bus.sdaMasterOe_n = ~sdaLow;
endmodule // dip_master
`default_nettype wire

// ===== sim/dip_link_checker.sv
// dip_link_checker: assertions on the two shared lines of the link
// assumes: lines already resolved in dip_if, one clk for both ends
`timescale 1ns/1ps
`default_nettype none
module dip_link_checker (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl,
   input wire logic sda,
   input wire logic sdaSlaveOut,
   input wire logic sdaSlaveOe_n,
   input wire logic sdaMasterOe_n
);
   // ------
   // frame tracking
   // ------
   logic       sclQ, sdaQ, live, startEv, stopEv, sclRise;
   logic [3:0] bitCnt;
   logic [2:0] byteIdx;
   logic [7:0] shreg;
   assign startEv = scl & sclQ & sdaQ & ~sda;
   assign stopEv  = scl & sclQ & ~sdaQ & sda;
   assign sclRise = scl & ~sclQ;
   // bit and byte position since the last start
   always_ff @(posedge clk) begin
      sclQ <= scl;
      sdaQ <= sda;
      if (!reset_n || stopEv) begin
         live <= 1'b0;
      end else if (startEv) begin
         live    <= 1'b1;
         bitCnt  <= 4'h0;
         byteIdx <= 3'h0;
      end else if (sclRise) begin
         shreg   <= {shreg[6:0], sda};
         bitCnt  <= (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
         byteIdx <= (bitCnt == 4'h8) ? byteIdx + 3'h1 : byteIdx;
      end
   end
   // ------
   // assertions
   // ------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   a_pull_only: assert property (!sdaSlaveOe_n |-> !sdaSlaveOut && live)
      else $error("slave drives data high or outside a transfer");
   a_ack_slot_only: assert property ($rose(scl) && !sdaSlaveOe_n |-> live && bitCnt == 4'h8)
      else $error("slave drives outside ack slot");
   a_hold_ack_high: assert property ($rose(sdaSlaveOe_n) |-> !scl)
      else $error("slave released ack with clock high");
   a_master_frees_ack: assert property (!sdaSlaveOe_n && scl |-> sdaMasterOe_n)
      else $error("master drives data in ack pulse");
   a_idle_clock_high: assert property (!live |-> scl)
      else $error("clock low outside transfer");
   a_start_form: assert property (!live && $fell(sda) |-> scl && $past(scl))
      else $error("data fell idle without clock high");
   a_stop_release: assert property (stopEv |=> sdaSlaveOe_n [*8])
      else $error("slave drives after stop");
   a_data_steady: assert property (live && scl && $past(scl) && !$stable(sda) |-> sda)
      else $error("data fell while clock high");
   a_read_no_ack: assert property (
      $rose(scl) && bitCnt == 4'h8 && byteIdx == 3'h0 && shreg[0] |-> sdaSlaveOe_n)
      else $error("read address acknowledged");
   a_extra_no_ack: assert property (
      $rose(scl) && bitCnt == 4'h8 && byteIdx > 3'h3 |-> sdaSlaveOe_n)
      else $error("extra data byte acknowledged");
   c_ack: cover property ($rose(scl) && bitCnt == 4'h8 && !sdaSlaveOe_n);
   c_extra: cover property ($rose(scl) && bitCnt == 4'h8 && byteIdx == 3'h4);
   c_stop: cover property (stopEv);
endmodule // dip_link_checker
`default_nettype wire

// ===== sim/dac_i2c_write_port_test.sv
// dac_i2c_write_port_test: master and dac port joined on one link
// assumes: 100 MHz clk; inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module dac_i2c_write_port_test;
   // ------
   // stimulus and model state
   // ------
   localparam int LIMIT = 100000;  // about 90k cycles of traffic
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        startReq = 1'b0;
   logic [39:0] txData = 40'h0;
   logic [2:0]  byteCount = 3'h0;
   logic        asyncUpdate_n = 1'b1;
   logic [1:0]  pinSt [3] = '{2'h0, 2'h0, 2'h0};
   logic [2:0]  floatHeld = 3'h0;
   logic [2:0]  selIn, selOut, selOe_n;
   logic        busy, done, poweredDown, addrReady;
   logic [4:0]  ackSeen;
   logic [15:0] dacCode, inputCode;
   logic [6:0]  ownAddr;
   logic [11:0] dacMid;
   int          bad_count = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          seed = 96099;
   int          expIn, expDac, expPd, armed;
   dip_if bus();
   dip_if busIdle();
   // second port sits on quiet lines: only its reset code is of interest
   assign busIdle.sclMasterOut  = 1'b0;
   assign busIdle.sclMasterOe_n = 1'b1;
   assign busIdle.sdaMasterOut  = 1'b0;
   assign busIdle.sdaMasterOe_n = 1'b1;
   always #5 clk = ~clk;
   // floating select pin reads back what the port drives
   always @(posedge clk) floatHeld <= (selOe_n & floatHeld) | (~selOe_n & selOut);
   always_comb begin
      for (int k = 0; k < 3; k++)
         selIn[k] = (pinSt[k] == dip_pkg::PIN_FLOAT) ? (selOe_n[k] ? floatHeld[k] : selOut[k])
                                                     : (pinSt[k] == dip_pkg::PIN_HIGH);
   end
   dip_master #(.MAX_BYTES(5)) i_dip_master (.clk(clk), .reset_n(reset_n), .bus(bus),
      .startReq(startReq), .txData(txData), .byteCount(byteCount), .busy(busy),
      .done(done), .ackSeen(ackSeen));
   dip_slave #(.RES_BITS(16), .MID_SCALE(1'b0)) i_dip_slave (.clk(clk), .reset_n(reset_n),
      .bus(bus), .selIn(selIn), .selOut(selOut), .selOe_n(selOe_n),
      .asyncUpdate_n(asyncUpdate_n), .dacCode(dacCode), .inputCode(inputCode),
      .poweredDown(poweredDown), .addrReady(addrReady));
   dip_slave #(.RES_BITS(12), .MID_SCALE(1'b1)) i_dip_slave_mid (.clk(clk), .reset_n(reset_n),
      .bus(busIdle), .selIn(selIn), .selOut(), .selOe_n(), .asyncUpdate_n(asyncUpdate_n),
      .dacCode(dacMid), .inputCode(), .poweredDown(), .addrReady());
   dip_link_checker i_dip_link_checker (.clk(clk), .reset_n(reset_n), .scl(bus.scl),
      .sda(bus.sda), .sdaSlaveOut(bus.sdaSlaveOut), .sdaSlaveOe_n(bus.sdaSlaveOe_n),
      .sdaMasterOe_n(bus.sdaMasterOe_n));
   // ------
   // tasks
   // ------
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // reset with random select pin ties and work out the expected address
   task automatic do_reset();
      int idx;
      @(negedge clk);
      reset_n = 1'b0;
      for (int k = 0; k < 3; k++)
         pinSt[k] = 2'({$random(seed)} % 3);
      repeat (12) @(negedge clk);
      reset_n = 1'b1;
      repeat (24) @(negedge clk);
      idx = 9 * pinSt[2] + 3 * pinSt[1] + pinSt[0];
      ownAddr = {3'(idx / 4 + 1), 2'b00, 2'(idx % 4)};
      expIn = 0;
      expDac = 0;
      expPd = 0;
      armed = 0;
      chk("addrReady", 16'h1, {15'h0, addrReady});
      chk("dacCode", 16'h0, dacCode);
      chk("dacMid", 16'h0800, {4'h0, dacMid});
      chk("poweredDown", 16'h0, {15'h0, poweredDown});
      $display("reset done: address %h", ownAddr);
   endtask
   // one write burst; kind 0 own address, 1 broadcast, 2 foreign
   task automatic xfer(input int kind, input int rw, input int n, input logic [3:0] cmd,
                       input bit updLow, input bit pulse);
      logic [6:0]  a;
      logic [15:0] w;
      logic [4:0]  ackExp;
      int          t;
      a = (kind == 0) ? ownAddr : (kind == 1) ? dip_pkg::GLOBAL_ADDR : ownAddr ^ 7'h04;
      w = 16'($random(seed));
      for (int k = 0; k < 5; k++)
         ackExp[k] = kind < 2 && rw == 0 && k < n && k < 4;
      @(negedge clk);
      txData = {a, rw[0], cmd, 4'($random(seed)), w, 8'($random(seed))};
      byteCount = 3'(n);
      startReq = 1'b1;
      asyncUpdate_n = !updLow;
      if (updLow) begin
         expPd = 0;
         if (armed)
            expDac = expIn;
      end
      @(negedge clk);
      startReq = 1'b0;
      chk("busy", 16'h1, {15'h0, busy});
      t = 0;
      while (done !== 1'b1 && t < 20000) begin
         @(negedge clk);
         t++;
      end
      chk("done", 16'h1, {15'h0, done});
      chk("busy", 16'h0, {15'h0, busy});
      armed = 0;
      if (ackExp[0] && n >= 4) begin
         armed = 1;
         if (cmd == 4'h0 || cmd == 4'h3)
            expIn = w;
         if (cmd == 4'h1 || cmd == 4'h3 || updLow) begin
            expDac = expIn;
            expPd = 0;
         end else if (cmd == 4'h4) begin
            expPd = 1;
         end
      end
      if (pulse) begin
         asyncUpdate_n = 1'b0;
         expPd = 0;
         if (armed)
            expDac = expIn;
         repeat (8) @(negedge clk);
      end
      asyncUpdate_n = 1'b1;
      repeat (8) @(negedge clk);
      chk("ackSeen", {11'h0, ackExp}, {11'h0, ackSeen});
      chk("inputCode", 16'(expIn), inputCode);
      chk("dacCode", 16'(expDac), dacCode);
      chk("poweredDown", 16'(expPd), {15'h0, poweredDown});
      $display("transfer done: kind %0d bytes %0d command %h", kind, n, cmd);
   endtask
   // ------
   // run
   // ------
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      do_reset();
      xfer(0, 0, 4, 4'h0, 0, 0);
      xfer(0, 0, 2, 4'h0, 0, 1);
      xfer(0, 0, 4, 4'h4, 0, 0);
      xfer(0, 0, 4, 4'hf, 0, 0);
      xfer(0, 0, 4, 4'h2, 0, 0);
      xfer(1, 0, 5, 4'h1, 0, 0);
      xfer(0, 0, 4, 4'h0, 0, 0);
      xfer(0, 0, 4, 4'h4, 1, 0);
      xfer(0, 0, 4, 4'h3, 0, 0);
      xfer(0, 1, 1, 4'h0, 0, 0);
      xfer(2, 0, 1, 4'h0, 0, 0);
      do_reset();
      xfer(0, 0, 1, 4'h0, 0, 0);
      print_verdict();
   end
endmodule // dac_i2c_write_port_test
`default_nettype wire
